//--- hamming_7_4_byte_codec.sv
// Hamming (7,4) encoder and decoder for 16-bit serial memory words
`timescale 1ns/100ps
`include "hamming_codec_cfg.svh"

module hamming_7_4_byte_codec
(
   input  wire logic        i_ref_clk,      // 40 MHz clock
   input  wire logic        i_nrst,         // Async reset, active low
   input  wire logic        i_enc_valid,    // Byte to encode is present
   input  wire logic [7:0]  i_enc_byte,     // Host byte to encode
   input  wire logic        i_dec_valid,    // Memory word to decode
   input  wire logic [15:0] i_dec_word,     // Word read from memory
   output logic             o_enc_valid,    // Encoded word ready pulse
   output logic [15:0]      o_enc_word,     // Encoded word, flags clear
   output logic             o_dec_valid,    // Decoded result pulse
   output logic [7:0]       o_dec_byte,     // Corrected host byte
   output logic             o_err_hi,       // Error pulse, high byte
   output logic             o_err_lo,       // Error pulse, low byte
   output logic [2:0]       o_syn_hi,       // Syndrome, high byte
   output logic [2:0]       o_syn_lo,       // Syndrome, low byte
   output logic [2:0]       o_loc_hi,       // Error location, high byte
   output logic [2:0]       o_loc_lo,       // Error location, low byte
   output logic             o_wb_valid,     // Write-back request pulse
   output logic [15:0]      o_wb_word       // Word with flags updated
);

   // =======================================================================
   // Parity helpers
   // parity equations
   function automatic hamming_codec_pkg::syndrome_t parity_of
   (
      input hamming_codec_pkg::nibble_t n
   );
      parity_of = {n[0] ^ n[1] ^ n[3],
                   n[0] ^ n[2] ^ n[3],
                   n[1] ^ n[2] ^ n[3]};
   endfunction : parity_of

   function automatic hamming_codec_pkg::codeword_t encode
   (
      input hamming_codec_pkg::nibble_t n
   );
      encode = {parity_of(n), n};
   endfunction : encode

   // =======================================================================
   // Per-byte decode, one copy per half of the word
   hamming_codec_pkg::syndrome_t syn_c   [2];
   hamming_codec_pkg::nibble_t   fix_c   [2];
   hamming_codec_pkg::err_loc_t  loc_c   [2];
   logic [7:0]                   wb_c    [2];

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_half
         logic [7:0]                 byte_in;
         hamming_codec_pkg::nibble_t info;
         assign byte_in = i_dec_word[g*`BYTE_W +: `BYTE_W];
         assign info    = byte_in[`NIB_W-1:0];

         always_comb
         begin
            syn_c[g] = parity_of(info) ^ byte_in[`CW_P2_BIT:`CW_P0_BIT];
            fix_c[g] = info;
            loc_c[g] = hamming_codec_pkg::LOC_NONE;
            // one flip per group corrected; two or more give bad data
            case (syn_c[g])
               `SYN_NONE: loc_c[g] = hamming_codec_pkg::LOC_NONE;
               `SYN_P0:   loc_c[g] = hamming_codec_pkg::LOC_P0;
               `SYN_P1:   loc_c[g] = hamming_codec_pkg::LOC_P1;
               `SYN_P2:   loc_c[g] = hamming_codec_pkg::LOC_P2;
               `SYN_I0:
               begin
                  fix_c[g][0] = ~info[0];
                  loc_c[g]    = hamming_codec_pkg::LOC_DATA;
               end
               `SYN_I1:
               begin
                  fix_c[g][1] = ~info[1];
                  loc_c[g]    = hamming_codec_pkg::LOC_DATA;
               end
               `SYN_I2:
               begin
                  fix_c[g][2] = ~info[2];
                  loc_c[g]    = hamming_codec_pkg::LOC_DATA;
               end
               `SYN_I3:
               begin
                  fix_c[g][3] = ~info[3];
                  loc_c[g]    = hamming_codec_pkg::LOC_DATA;
               end
               default: loc_c[g] = hamming_codec_pkg::LOC_NONE;
            endcase
            // flag sticks once set; codeword rewritten clean
            wb_c[g] = {byte_in[`FLAG_BIT] | (syn_c[g] != `SYN_NONE),
                       encode(fix_c[g])};
         end
      end
   endgenerate

   // =======================================================================
   // Output registers
   logic        enc_valid_d, enc_valid_q;
   logic [15:0] enc_word_d,  enc_word_q;
   logic        dec_valid_d, dec_valid_q;
   logic [7:0]  dec_byte_d,  dec_byte_q;
   logic        err_hi_d,    err_hi_q;
   logic        err_lo_d,    err_lo_q;
   logic [2:0]  syn_hi_d,    syn_hi_q;
   logic [2:0]  syn_lo_d,    syn_lo_q;
   logic [2:0]  loc_hi_d,    loc_hi_q;
   logic [2:0]  loc_lo_d,    loc_lo_q;
   logic        wb_valid_d,  wb_valid_q;
   logic [15:0] wb_word_d,   wb_word_q;

   always_comb
   begin
      enc_valid_d = i_enc_valid;
      enc_word_d  = enc_word_q;
      // two bytes per word, flags start clear
      if (i_enc_valid)
         enc_word_d = {1'b0, encode(i_enc_byte[7:4]),
                       1'b0, encode(i_enc_byte[3:0])};
      // Decoded byte, syndromes, locations and write-back word hold their last value between requests; pulses do not
      dec_valid_d = i_dec_valid;
      dec_byte_d  = dec_byte_q;
      syn_hi_d    = syn_hi_q;
      syn_lo_d    = syn_lo_q;
      loc_hi_d    = loc_hi_q;
      loc_lo_d    = loc_lo_q;
      wb_word_d   = wb_word_q;
      err_hi_d    = i_dec_valid & (syn_c[1] != `SYN_NONE);
      err_lo_d    = i_dec_valid & (syn_c[0] != `SYN_NONE);
      // write back only when something was wrong
      wb_valid_d  = err_hi_d | err_lo_d;
      if (i_dec_valid)
      begin
         dec_byte_d = {fix_c[1], fix_c[0]};
         syn_hi_d   = syn_c[1];
         syn_lo_d   = syn_c[0];
         loc_hi_d   = loc_c[1];
         loc_lo_d   = loc_c[0];
         wb_word_d  = {wb_c[1], wb_c[0]};
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         enc_valid_q <= 1'b0;
         enc_word_q  <= 16'h0000;
         dec_valid_q <= 1'b0;
         dec_byte_q  <= 8'h00;
         err_hi_q    <= 1'b0;
         err_lo_q    <= 1'b0;
         syn_hi_q    <= 3'h0;
         syn_lo_q    <= 3'h0;
         loc_hi_q    <= 3'h0;
         loc_lo_q    <= 3'h0;
         wb_valid_q  <= 1'b0;
         wb_word_q   <= 16'h0000;
      end
      else
      begin
         enc_valid_q <= enc_valid_d;
         enc_word_q  <= enc_word_d;
         dec_valid_q <= dec_valid_d;
         dec_byte_q  <= dec_byte_d;
         err_hi_q    <= err_hi_d;
         err_lo_q    <= err_lo_d;
         syn_hi_q    <= syn_hi_d;
         syn_lo_q    <= syn_lo_d;
         loc_hi_q    <= loc_hi_d;
         loc_lo_q    <= loc_lo_d;
         wb_valid_q  <= wb_valid_d;
         wb_word_q   <= wb_word_d;
      end
   end

   assign o_enc_valid = enc_valid_q;
   assign o_enc_word  = enc_word_q;
   assign o_dec_valid = dec_valid_q;
   assign o_dec_byte  = dec_byte_q;
   assign o_err_hi    = err_hi_q;
   assign o_err_lo    = err_lo_q;
   assign o_syn_hi    = syn_hi_q;
   assign o_syn_lo    = syn_lo_q;
   assign o_loc_hi    = loc_hi_q;
   assign o_loc_lo    = loc_lo_q;
   assign o_wb_valid  = wb_valid_q;
   assign o_wb_word   = wb_word_q;

   // =======================================================================
   // Checks
   AST_ENC_PARITY:
   assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      i_enc_valid |=> o_enc_word[6:4] ==
         {$past(i_enc_byte[0]) ^ $past(i_enc_byte[1]) ^ $past(i_enc_byte[3]),
          $past(i_enc_byte[0]) ^ $past(i_enc_byte[2]) ^ $past(i_enc_byte[3]),
          $past(i_enc_byte[1]) ^ $past(i_enc_byte[2]) ^ $past(i_enc_byte[3])})
      else $error("Low encoded parity wrong");

   AST_ENC_ORDER:
   assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      i_enc_valid |=> o_enc_word[3:0] == $past(i_enc_byte[3:0]) &&
         o_enc_word[11:8] == $past(i_enc_byte[7:4]) &&
         !o_enc_word[15] && !o_enc_word[7])
      else $error("Encoded word layout wrong");

   AST_CLEAN_WORD:
   assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      i_dec_valid && parity_of(i_dec_word[3:0]) == i_dec_word[6:4] &&
         parity_of(i_dec_word[11:8]) == i_dec_word[14:12] |=>
         o_dec_valid && !o_err_hi && !o_err_lo && !o_wb_valid &&
         o_syn_hi == 3'h0 && o_syn_lo == 3'h0 &&
         o_dec_byte == {$past(i_dec_word[11:8]), $past(i_dec_word[3:0])})
      else $error("Clean word flagged");

   // Re-encoded words must carry even parity in every group
   AST_WB_EVEN:
   assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      o_dec_valid |->
         !(o_wb_word[6] ^ o_wb_word[0] ^ o_wb_word[1] ^ o_wb_word[3]) &&
         !(o_wb_word[5] ^ o_wb_word[0] ^ o_wb_word[2] ^ o_wb_word[3]) &&
         !(o_wb_word[4] ^ o_wb_word[1] ^ o_wb_word[2] ^ o_wb_word[3]) &&
         !(o_wb_word[14] ^ o_wb_word[8] ^ o_wb_word[9] ^ o_wb_word[11]) &&
         !(o_wb_word[13] ^ o_wb_word[8] ^ o_wb_word[10] ^ o_wb_word[11]) &&
         !(o_wb_word[12] ^ o_wb_word[9] ^ o_wb_word[10] ^ o_wb_word[11]))
      else $error("Write-back parity odd");

   AST_ERR_HI_PULSE:
   assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      o_err_hi |-> o_dec_valid && o_syn_hi != 3'h0 && o_wb_valid)
      else $error("High error pulse without decode");

   AST_PARITY_ONLY:
   assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      i_dec_valid && syn_c[0] inside {3'h1, 3'h2, 3'h4} |=>
         o_dec_byte[3:0] == $past(i_dec_word[3:0]) && o_err_lo)
      else $error("Parity error changed data");

   AST_FIX_I0:
   assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      i_dec_valid && syn_c[0] == `SYN_I0 |=>
         o_dec_byte[3:0] == ($past(i_dec_word[3:0]) ^ 4'h1))
      else $error("I0 not corrected");

   AST_FIX_I1:
   assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      i_dec_valid && syn_c[1] == `SYN_I1 |=>
         o_dec_byte[7:4] == ($past(i_dec_word[11:8]) ^ 4'h2))
      else $error("I1 not corrected");

   AST_FIX_I2:
   assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      i_dec_valid && syn_c[0] == `SYN_I2 |=>
         o_dec_byte[3:0] == ($past(i_dec_word[3:0]) ^ 4'h4))
      else $error("I2 not corrected");

   AST_FIX_I3:
   assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      i_dec_valid && syn_c[1] == `SYN_I3 |=>
         o_dec_byte[7:4] == ($past(i_dec_word[11:8]) ^ 4'h8))
      else $error("I3 not corrected");

   AST_FLAG_STICKY:
   assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      o_wb_valid |-> o_wb_word[15] == (o_err_hi | $past(i_dec_word[15])) &&
         o_wb_word[7] == (o_err_lo | $past(i_dec_word[7])))
      else $error("History flag not updated");

   AST_SYN_TIMING:
   assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      i_dec_valid |=> o_dec_valid && o_syn_lo == $past(syn_c[0]) &&
         o_err_lo == ($past(syn_c[0]) != 3'h0) ##1
         (!o_err_lo || $past(i_dec_valid)))
      else $error("Syndrome not one cycle later");

endmodule : hamming_7_4_byte_codec

//--- hamming_7_4_byte_codec_test.sv
// Self-checking bench for the Hamming (7,4) byte codec
`timescale 1ns/100ps
module hamming_7_4_byte_codec_test;
   // ======================================================================
   // Signals
   logic        ref_clk;
   logic        nrst;
   logic        enc_valid;
   logic        dec_valid;
   logic [7:0]  enc_byte;
   logic [3:0]  addr;
   logic [15:0] flip;
   logic [15:0] rd_word;
   logic        o_enc_valid, o_dec_valid, o_err_hi, o_err_lo, o_wb_valid;
   logic [15:0] o_enc_word, o_wb_word;
   logic [7:0]  o_dec_byte;
   logic [2:0]  o_syn_hi, o_syn_lo, o_loc_hi, o_loc_lo;
   logic [1:0]  flags [16];
   int          failures;
   int          check_count;

   hamming_7_4_byte_codec u_hamming_7_4_byte_codec
   (
      .i_ref_clk(ref_clk), .i_nrst(nrst), .i_enc_valid(enc_valid),
      .i_enc_byte(enc_byte), .i_dec_valid(dec_valid), .i_dec_word(rd_word),
      .o_enc_valid(o_enc_valid), .o_enc_word(o_enc_word),
      .o_dec_valid(o_dec_valid), .o_dec_byte(o_dec_byte),
      .o_err_hi(o_err_hi), .o_err_lo(o_err_lo), .o_syn_hi(o_syn_hi),
      .o_syn_lo(o_syn_lo), .o_loc_hi(o_loc_hi), .o_loc_lo(o_loc_lo),
      .o_wb_valid(o_wb_valid), .o_wb_word(o_wb_word)
   );

   word_store u_word_store
   (
      .i_ref_clk(ref_clk), .i_addr(addr), .i_flip(flip),
      .i_enc_valid(o_enc_valid), .i_enc_word(o_enc_word),
      .i_wb_valid(o_wb_valid), .i_wb_word(o_wb_word), .o_rd_word(rd_word)
   );

   // ======================================================================
   // Helpers
   function automatic logic [6:0] enc(input logic [3:0] d);
      return {d[0]^d[1]^d[3], d[0]^d[2]^d[3], d[1]^d[2]^d[3], d};
   endfunction : enc

   // Expected syndrome for one flipped codeword bit, by position
   function automatic logic [2:0] syn_of(input logic [6:0] m);
      case (m)
         7'h01: return 3'h6;
         7'h02: return 3'h5;
         7'h04: return 3'h3;
         7'h08: return 3'h7;
         7'h10: return 3'h1;
         7'h20: return 3'h2;
         7'h40: return 3'h4;
         default: return 3'h0;
      endcase
   endfunction : syn_of

   function automatic logic [2:0] loc_of(input logic [6:0] m);
      if (m == 7'h00)
         return hamming_codec_pkg::LOC_NONE;
      if (m == 7'h10)
         return hamming_codec_pkg::LOC_P0;
      if (m == 7'h20)
         return hamming_codec_pkg::LOC_P1;
      if (m == 7'h40)
         return hamming_codec_pkg::LOC_P2;
      return hamming_codec_pkg::LOC_DATA;
   endfunction : loc_of

   task automatic chk(input logic ok, input string what);
      check_count++;
      if (ok !== 1'b1)
      begin
         failures++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask : chk

   task automatic wrap_up;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up

   // ======================================================================
   // Scenarios
   task automatic t_encode_all;
      logic [3:0] m;
      enc_valid = 1'b1;
      enc_byte = 8'h0F;
      addr = 4'h0;
      for (int n = 1; n <= 16; n++)
      begin
         @(negedge ref_clk);
         m = 4'(n - 1);
         chk(o_enc_valid === 1'b1, "encode pulse missing");
         chk(o_enc_word === {1'b0, enc(m), 1'b0, enc(~m)}, "encode word");
         enc_byte = {4'(n), ~4'(n)};
         addr = 4'(n);
         enc_valid = (n < 16);
      end
      @(negedge ref_clk);
      chk(o_enc_valid === 1'b0, "encode pulse too long");
   endtask : t_encode_all

   task automatic dec_one(input logic [3:0] a, input logic [6:0] fh,
                          input logic [6:0] fl);
      logic [1:0] fg;
      fg = flags[a];
      addr = a;
      flip = {1'b0, fh, 1'b0, fl};
      dec_valid = 1'b1;
      @(negedge ref_clk);
      dec_valid = 1'b0;
      flip = 16'h0000;
      chk(o_dec_valid === 1'b1, "decode pulse missing");
      chk(o_dec_byte === {a, ~a}, "corrected byte");
      chk({o_syn_hi, o_syn_lo} === {syn_of(fh), syn_of(fl)}, "syndrome");
      chk({o_err_hi, o_err_lo} === {|fh, |fl}, "error pulse");
      chk({o_loc_hi, o_loc_lo} === {loc_of(fh), loc_of(fl)}, "location");
      chk(o_wb_valid === (|{fh, fl}), "write-back strobe");
      chk(o_wb_word === {fg[1] | (|fh), enc(a), fg[0] | (|fl), enc(~a)},
          "write-back word");
      flags[a] = fg | {|fh, |fl};
      @(negedge ref_clk);
      chk({o_dec_valid, o_err_hi, o_err_lo, o_wb_valid} === 4'h0,
          "decode pulses too long");
   endtask : dec_one

   task automatic t_decode_clean;
      for (int a = 0; a < 16; a++)
         dec_one(4'(a), 7'h00, 7'h00);
   endtask : t_decode_clean

   // Every single-bit position, mirrored between the two bytes
   task automatic t_decode_single;
      for (int p = 0; p < 7; p++)
         dec_one(4'(p), 7'(7'h01 << p), 7'(7'h40 >> p));
   endtask : t_decode_single

   // Flags written back must survive a clean re-read without a write
   task automatic t_decode_flagged;
      for (int p = 0; p < 7; p++)
         dec_one(4'(p), 7'h00, 7'h00);
   endtask : t_decode_flagged

   // ======================================================================
   // Clock, watchdog and main sequence
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   initial
   begin
      repeat (2000) @(posedge ref_clk);
      failures++;
      wrap_up();
   end

   initial
   begin
      nrst = 1'b0;
      enc_valid = 1'b0;
      dec_valid = 1'b0;
      enc_byte = 8'h00;
      addr = 4'h0;
      flip = 16'h0000;
      failures = 0;
      check_count = 0;
      foreach (flags[i])
         flags[i] = 2'b00;
      repeat (20) @(negedge ref_clk);
      nrst = 1'b1;
      @(negedge ref_clk);
      t_encode_all();
      t_decode_clean();
      t_decode_single();
      t_decode_flagged();
      wrap_up();
   end
endmodule : hamming_7_4_byte_codec_test

//--- hamming_codec_cfg.svh
// Constants for the Hamming (7,4) byte codec
`ifndef HAMMING_CODEC_CFG_SVH
`define HAMMING_CODEC_CFG_SVH

// ==========================================================================
// Codeword layout
`define CW_W          7
`define NIB_W         4
`define SYN_W         3
`define BYTE_W        8
`define WORD_W        16
`define FLAG_BIT      7
`define CW_P2_BIT     6
`define CW_P1_BIT     5
`define CW_P0_BIT     4
`define HI_BYTE_LSB   8

// ==========================================================================
// Syndrome codes
`define SYN_NONE      3'h0
`define SYN_P0        3'h1
`define SYN_P1        3'h2
`define SYN_I2        3'h3
`define SYN_P2        3'h4
`define SYN_I1        3'h5
`define SYN_I0        3'h6
`define SYN_I3        3'h7

`endif

//--- hamming_codec_pkg.sv
// Types for the Hamming (7,4) byte codec
package hamming_codec_pkg;
   typedef logic [6:0]  codeword_t;
   typedef logic [3:0]  nibble_t;
   typedef logic [2:0]  syndrome_t;
   typedef logic [15:0] mem_word_t;

   typedef enum logic [2:0]
   {
      LOC_NONE = 3'b000,
      LOC_P0   = 3'b001,
      LOC_P1   = 3'b010,
      LOC_P2   = 3'b011,
      LOC_DATA = 3'b100
   } err_loc_t;
endpackage : hamming_codec_pkg

//--- word_store.sv
// Behavioural host-side word store that feeds the codec
`timescale 1ns/100ps
module word_store
(
   input  wire logic        i_ref_clk,   // Host clock
   input  wire logic [3:0]  i_addr,      // Word address
   input  wire logic [15:0] i_flip,      // Bit-flip mask on read
   input  wire logic        i_enc_valid, // Encoded word strobe
   input  wire logic [15:0] i_enc_word,  // Encoded word
   input  wire logic        i_wb_valid,  // Write-back strobe
   input  wire logic [15:0] i_wb_word,   // Write-back word
   output logic      [15:0] o_rd_word    // Stored word with flips
);
   // ======================================================================
   // Storage
   logic [15:0] mem_q [16];
   logic [3:0]  addr_q;

   always_ff @(posedge i_ref_clk)
   begin
      addr_q <= i_addr;
      if (i_enc_valid)
         mem_q[addr_q] <= i_enc_word;
      else if (i_wb_valid)
         mem_q[addr_q] <= i_wb_word;
   end

   // Worn cells modelled as flips on the read path only
   assign o_rd_word = mem_q[i_addr] ^ i_flip;
endmodule : word_store
